// ### gpe_pkg.sv
// Constants for the sixteen-pin general-purpose port with edge events.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
// Overview of operation
// RULE_01 - Direction bit per pin: 0 selects output, 1 selects input.
// RULE_02 - After reset every pin is an input and nothing is driven.
// RULE_03 - Writing 1 to drive_bit_setter sets latch bits; zeros do nothing.
// RULE_04 - Writing 1 to drive_bit_clearer clears latch bits; zeros do nothing.
// RULE_05 - drive_value_latch is writable directly and sets levels of output pins.
// RULE_06 - Latch writes never drive a pin that is configured as input.
// RULE_07 - Reading the setter or clearer returns the latch, not the pins.
// RULE_08 - pin_level_sample returns the present level of every pin.
// RULE_09 - Pin samples are synchronised to the clock before edge detection.
// RULE_10 - Edge select pair decodes to off, falling, rising or both edges.
// RULE_11 - Edges are seen whatever the direction, including self-driven toggles.
// RULE_12 - Writing 1 to upward_edge_setter sets upward_edge_select bits.
// RULE_13 - Writing 1 to upward_edge_clearer clears upward_edge_select bits.
// RULE_14 - Downward setter and clearer set and clear downward_edge_select bits.
// RULE_15 - Edge alias reads return the matching hidden edge select register.
// RULE_16 - Edge select registers have no address of their own.
// RULE_17 - Events pass only while bit 0 of bank_event_gate is 1.
// RULE_18 - Reserved bits of bank_event_gate read zero and ignore writes.
// RULE_19 - Sixteen event outputs, each usable as interrupt and DMA event.
// RULE_20 - A debug halt changes nothing; the block keeps running.
// RULE_21 - Software selects input direction to leave a pin undriven.
// RULE_22 - Pin bits sit in 15..0; bits 31..16 read zero, ignore writes.
// RULE_23 - Reading drive_value_latch returns the latch, not the pin level.
// RULE_24 - Each selected edge gives a one-cycle pulse from sample compare.
package gpe_pkg;
   localparam int PINS = 16;
   localparam logic [15:0] OFS_GATE = 16'h8000;
   localparam logic [15:0] OFS_DIR = 16'h0010;
   localparam logic [15:0] OFS_LATCH = 16'h0014;
   localparam logic [15:0] OFS_DSET = 16'h0018;
   localparam logic [15:0] OFS_DCLR = 16'h001C;
   localparam logic [15:0] OFS_LEVEL = 16'h0020;
   localparam logic [15:0] OFS_USET = 16'h0024;
   localparam logic [15:0] OFS_UCLR = 16'h0028;
   localparam logic [15:0] OFS_WSET = 16'h002C;
   localparam logic [15:0] OFS_WCLR = 16'h0030;
   localparam logic [15:0] RST_DIR = 16'hFFFF;
   localparam logic [15:0] RST_LATCH = 16'h0000;
   localparam logic [15:0] RST_EDGE = 16'h0000;
   localparam logic RST_GATE = 1'h0;
   localparam int GATE_BIT = 0;
endpackage : gpe_pkg

// ### gpe_port.sv
// Sixteen-pin port with direction, output latch, alias registers and edge events.
// Assumes pins arrive synchronous enough for a two-stage synchroniser.
`timescale 1ns/1ps
module gpe_port
   import gpe_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [15:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   output logic wbErr,
   input wire logic [15:0] pinIn,
   output logic [15:0] pinOut,
   output logic [15:0] pinOeN,
   output logic [15:0] pinEventLine
);
   typedef struct packed {
      logic [15:0] dir;
      logic [15:0] latch;
      logic [15:0] upSel;
      logic [15:0] downSel;
      logic gate;
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] prev;
      logic [15:0] events;
      logic ack;
      logic err;
      logic [31:0] rdata;
   } gpe_state_t;

   gpe_state_t st;
   gpe_state_t next_st;
   logic req;
   logic [15:0] wmask;
   logic [15:0] wval;
   logic hit;
   logic [15:0] rise;
   logic [15:0] fall;

   // Low sixteen bits of a write after byte-lane masking
   function automatic logic [15:0] gpe_lanes(input logic [31:0] d, input logic [3:0] s);
      gpe_lanes = {d[15:8] & {8{s[1]}}, d[7:0] & {8{s[0]}}};
   endfunction : gpe_lanes

   // Address decode shared by read and write paths
   function automatic logic gpe_known(input logic [15:0] a);
      gpe_known = (a == OFS_GATE) || (a == OFS_DIR) || (a == OFS_LATCH) || (a == OFS_DSET) ||
         (a == OFS_DCLR) || (a == OFS_LEVEL) || (a == OFS_USET) || (a == OFS_UCLR) ||
         (a == OFS_WSET) || (a == OFS_WCLR);
   endfunction : gpe_known

   // New request only when no answer is standing, so ack is one cycle
   assign req = wbCyc && wbStb && !st.ack && !st.err;
   assign hit = gpe_known(wbAdr);
   assign wmask = gpe_lanes({32{1'b1}}, wbSel);
   assign wval = gpe_lanes(wbDatW, wbSel);
   // RULE_10 edge decode
   assign rise = st.sync2 & ~st.prev & st.upSel;
   assign fall = ~st.sync2 & st.prev & st.downSel;

   // Next state: bus slave, registers, synchroniser and edge pulses
   always_comb begin
      next_st = st;
      next_st.ack = req && hit;
      next_st.err = req && !hit;
      next_st.rdata = 32'h0000_0000;
      // RULE_09 two-stage sync
      next_st.sync1 = pinIn;
      next_st.sync2 = st.sync1;
      next_st.prev = st.sync2;
      // RULE_24 pulse per edge; RULE_11 and RULE_17 gate
      next_st.events = (rise | fall) & {16{st.gate}};
      if (req && hit && wbWe) begin
         case (wbAdr)
            // RULE_01 direction write
            OFS_DIR: next_st.dir = (st.dir & ~wmask) | wval;
            // RULE_05 direct latch write
            OFS_LATCH: next_st.latch = (st.latch & ~wmask) | wval;
            // RULE_03 set aliases
            OFS_DSET: next_st.latch = st.latch | wval;
            // RULE_04 clear aliases
            OFS_DCLR: next_st.latch = st.latch & ~wval;
            // RULE_12 upward set
            OFS_USET: next_st.upSel = st.upSel | wval;
            // RULE_13 upward clear
            OFS_UCLR: next_st.upSel = st.upSel & ~wval;
            // RULE_14 downward set and clear
            OFS_WSET: next_st.downSel = st.downSel | wval;
            OFS_WCLR: next_st.downSel = st.downSel & ~wval;
            // RULE_18 only bit 0 stored
            OFS_GATE: begin
               if (wbSel[0]) begin
                  next_st.gate = wbDatW[GATE_BIT];
               end
            end
            default: next_st.gate = st.gate;
         endcase
      end
      if (req && hit && !wbWe) begin
         // RULE_22 upper bits zero; RULE_16 no direct edge select address
         case (wbAdr)
            OFS_DIR: next_st.rdata = {16'h0000, st.dir};
            // RULE_23 and RULE_07 latch readback
            OFS_LATCH, OFS_DSET, OFS_DCLR: next_st.rdata = {16'h0000, st.latch};
            // RULE_08 pin level
            OFS_LEVEL: next_st.rdata = {16'h0000, st.sync2};
            // RULE_15 alias readback
            OFS_USET, OFS_UCLR: next_st.rdata = {16'h0000, st.upSel};
            OFS_WSET, OFS_WCLR: next_st.rdata = {16'h0000, st.downSel};
            OFS_GATE: next_st.rdata = {31'h0000_0000, st.gate};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register; RULE_02 all inputs at reset; RULE_20 no halt input exists
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.dir <= RST_DIR;
         st.latch <= RST_LATCH;
         st.upSel <= RST_EDGE;
         st.downSel <= RST_EDGE;
         st.gate <= RST_GATE;
      end else begin
         st <= next_st;
      end
   end

   // RULE_06 and RULE_21 buffer enabled only for output pins (enable low)
   assign pinOut = st.latch;
   assign pinOeN = st.dir;
   // RULE_19 sixteen event lines
   assign pinEventLine = st.events;
   assign wbAck = st.ack;
   assign wbErr = st.err;
   assign wbDatR = st.rdata;

   // Checks below watch the state struct as well as the ports, so the hidden
   // edge select registers are covered even though no address reads them directly.
   // Every check except the reset one is switched off while reset is high.

   // Full-word write taken at one mapped address
   sequence take_write_seq(logic [15:0] adr);
      req && hit && wbWe && wbAdr == adr && wbSel == 4'hF;
   endsequence

   // Read taken at one mapped address
   sequence take_read_seq(logic [15:0] adr);
      req && hit && !wbWe && wbAdr == adr;
   endsequence

   // Rising edge seen on pin 1 while only its upward select is set
   sequence rise_seq;
      st.sync2[1] && !st.prev[1] && st.upSel[1] && !st.downSel[1] && st.gate;
   endsequence

   // Falling edge seen on pin 2 while only its downward select is set
   sequence fall_seq;
      !st.sync2[2] && st.prev[2] && st.downSel[2] && !st.upSel[2] && st.gate;
   endsequence

   // Any edge seen on pin 3 while both selects are set
   sequence both_seq;
      (st.sync2[3] != st.prev[3]) && st.upSel[3] && st.downSel[3] && st.gate;
   endsequence

   // One high cycle on an event line, then low again
   sequence pulse_seq(int n);
      pinEventLine[n] ##1 !pinEventLine[n];
   endsequence

   // Reset must leave every pad undriven and the bus and event lines quiet
   // RULE_02 reset state
   reset_idle_a: assert property (@(posedge clock) // RULE_02
      rst |=> pinOeN == RST_DIR && pinEventLine == 16'h0000 && !wbAck && !wbErr)
      else $error("reset state wrong");

   // RULE_03 set alias sets
   set_alias_a: assert property (@(posedge clock) disable iff (rst) // RULE_03
      take_write_seq(OFS_DSET) |=> ((st.latch & $past(wbDatW[15:0])) == $past(wbDatW[15:0])))
      else $error("set alias failed");

   // RULE_04 clear alias clears
   clr_alias_a: assert property (@(posedge clock) disable iff (rst) // RULE_04
      take_write_seq(OFS_DCLR) |=> ((st.latch & $past(wbDatW[15:0])) == 16'h0000))
      else $error("clear alias failed");

   // A latch write of any kind must never touch the drive enables
   // RULE_06 input pins undriven
   dir_drive_a: assert property (@(posedge clock) disable iff (rst) // RULE_06
      (take_write_seq(OFS_LATCH) or take_write_seq(OFS_DSET) or take_write_seq(OFS_DCLR))
      |=> pinOeN == $past(pinOeN))
      else $error("drive enable wrong");

   // RULE_01 direction write
   dir_write_a: assert property (@(posedge clock) disable iff (rst) // RULE_01
      take_write_seq(OFS_DIR) |=> pinOeN == $past(wbDatW[15:0]))
      else $error("direction write lost");

   // RULE_05 direct latch write
   lat_write_a: assert property (@(posedge clock) disable iff (rst) // RULE_05
      take_write_seq(OFS_LATCH) |=> pinOut == $past(wbDatW[15:0]))
      else $error("latch write lost");

   // RULE_17 gate off blocks events
   gate_block_a: assert property (@(posedge clock) disable iff (rst) // RULE_17
      !$past(st.gate) |-> pinEventLine == 16'h0000)
      else $error("event passed while gated");

   // RULE_17 gate write
   gate_write_a: assert property (@(posedge clock) disable iff (rst) // RULE_17
      take_write_seq(OFS_GATE) |=> st.gate == $past(wbDatW[GATE_BIT]))
      else $error("gate write lost");

   // RULE_24 rising pulse
   rise_pulse_a: assert property (@(posedge clock) disable iff (rst) // RULE_24
      rise_seq |=> pulse_seq(1))
      else $error("rising pulse missing");

   // RULE_10 falling pulse
   fall_pulse_a: assert property (@(posedge clock) disable iff (rst) // RULE_10
      fall_seq |=> pulse_seq(2))
      else $error("falling pulse missing");

   // RULE_10 both edges
   both_edge_a: assert property (@(posedge clock) disable iff (rst) // RULE_10
      both_seq |=> pinEventLine[3])
      else $error("either-edge pulse missing");

   // RULE_10 disabled edges quiet
   edge_off_a: assert property (@(posedge clock) disable iff (rst) // RULE_10
      ($past(st.upSel) == 16'h0000 && $past(st.downSel) == 16'h0000) |-> pinEventLine == 16'h0000)
      else $error("event with no edge selected");

   // The pad is two flops deep; a shorter path would risk metastable edges
   // RULE_09 sync depth
   sync_lag_a: assert property (@(posedge clock) disable iff (rst) // RULE_09
      st.sync2 == $past(pinIn, 2))
      else $error("synchroniser depth wrong");

   // Level read returns the synchronised pad, hence the three-cycle look back
   // RULE_08 level read
   level_read_a: assert property (@(posedge clock) disable iff (rst) // RULE_08
      take_read_seq(OFS_LEVEL) |=> wbDatR == {16'h0000, $past(pinIn, 3)})
      else $error("pin level read wrong");

   // RULE_07 alias reads latch
   latch_read_a: assert property (@(posedge clock) disable iff (rst) // RULE_07
      (take_read_seq(OFS_DSET) or take_read_seq(OFS_DCLR) or take_read_seq(OFS_LATCH))
      |=> wbDatR == {16'h0000, $past(pinOut)})
      else $error("latch readback wrong");

   // RULE_12 upward set
   up_set_a: assert property (@(posedge clock) disable iff (rst) // RULE_12
      take_write_seq(OFS_USET) |=> ((st.upSel & $past(wbDatW[15:0])) == $past(wbDatW[15:0])))
      else $error("upward set failed");

   // RULE_13 upward clear
   up_clr_a: assert property (@(posedge clock) disable iff (rst) // RULE_13
      take_write_seq(OFS_UCLR) |=> ((st.upSel & $past(wbDatW[15:0])) == 16'h0000))
      else $error("upward clear failed");

   // RULE_14 downward set
   down_set_a: assert property (@(posedge clock) disable iff (rst) // RULE_14
      take_write_seq(OFS_WSET) |=> ((st.downSel & $past(wbDatW[15:0])) == $past(wbDatW[15:0])))
      else $error("downward set failed");

   // RULE_14 downward clear
   down_clr_a: assert property (@(posedge clock) disable iff (rst) // RULE_14
      take_write_seq(OFS_WCLR) |=> ((st.downSel & $past(wbDatW[15:0])) == 16'h0000))
      else $error("downward clear failed");

   // RULE_15 upward alias read
   up_read_a: assert property (@(posedge clock) disable iff (rst) // RULE_15
      (take_read_seq(OFS_USET) or take_read_seq(OFS_UCLR)) |=> wbDatR == {16'h0000, $past(st.upSel)})
      else $error("upward alias read wrong");

   // RULE_15 downward alias read
   down_read_a: assert property (@(posedge clock) disable iff (rst) // RULE_15
      (take_read_seq(OFS_WSET) or take_read_seq(OFS_WCLR)) |=> wbDatR == {16'h0000, $past(st.downSel)})
      else $error("downward alias read wrong");

   // RULE_18 gate read upper bits zero
   gate_read_a: assert property (@(posedge clock) disable iff (rst) // RULE_18
      take_read_seq(OFS_GATE) |=> wbAck && wbDatR[31:1] == 31'h0000_0000)
      else $error("gate reserved bits nonzero");

   // Unmapped offsets, the hidden selects among them, answer with an error
   // RULE_16 no direct address
   err_unmapped_a: assert property (@(posedge clock) disable iff (rst) // RULE_16
      (req && !hit) |=> wbErr && !wbAck && wbDatR == 32'h0000_0000)
      else $error("unmapped access not refused");

   // RULE_16 refused write inert
   err_inert_a: assert property (@(posedge clock) disable iff (rst) // RULE_16
      (req && !hit) |=> $stable(st.latch) && $stable(st.dir) && $stable(st.upSel) && $stable(st.downSel))
      else $error("refused write changed state");

   // RULE_22 mapped access acked
   ack_mapped_a: assert property (@(posedge clock) disable iff (rst) // RULE_22
      (req && hit) |=> wbAck && !wbErr)
      else $error("mapped access not acknowledged");

   // Write answers carry zero data so a stale read value never leaks
   // RULE_22 write data zero
   wr_data_zero_a: assert property (@(posedge clock) disable iff (rst) // RULE_22
      (req && hit && wbWe) |=> wbDatR == 32'h0000_0000)
      else $error("write answer carried data");

   // RULE_22 one-cycle answer, upper bits zero
   bus_ack_a: assert property (@(posedge clock) disable iff (rst) // RULE_22
      wbAck |=> !wbAck && wbDatR[31:16] == 16'h0000)
      else $error("ack or upper bits wrong");
endmodule : gpe_port

// ### gpe_pin_model.sv
// Board side of the sixteen pads: resolves each pad from the port and the outside world.
// Assumes an undriven pad simply follows whatever level the bench applies from outside.
`timescale 1ns/1ps
module gpe_pin_model
   import gpe_pkg::*;
(
   input wire logic [15:0] pinOut,
   input wire logic [15:0] pinOeN,
   input wire logic [15:0] extLevel,
   output logic [15:0] pinIn
);
   // pad follows port only when enabled
   assign pinIn = (pinOut & ~pinOeN) | (extLevel & pinOeN);
endmodule : gpe_pin_model

// ### gpio_port_with_edge_events_test.sv
// Self-checking bench for the port: Wishbone register traffic plus pad-driven edge events.
// Assumes the single-cycle Wishbone answer and the three-edge event lag of the port.
`timescale 1ns/1ps
module gpio_port_with_edge_events_test
   import gpe_pkg::*;
   ;
   logic clock, rst, wbCyc, wbStb, wbWe, wbAck, wbErr;
   logic [15:0] wbAdr, pinIn, pinOut, pinOeN, pinEventLine, extLevel, dir, lat;
   logic [3:0] wbSel;
   logic [31:0] wbDatW, wbDatR, seed;
   logic [32:0] qExp[$];
   logic [15:0] qEv[$];
   int failCount, nTests;
   gpe_port gpe_port_inst(.clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .wbErr(wbErr),
      .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN), .pinEventLine(pinEventLine));
   gpe_pin_model gpe_pin_model_inst(.pinOut(pinOut), .pinOeN(pinOeN), .extLevel(extLevel), .pinIn(pinIn));
   // Free-running 50 MHz clock
   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic giveVerdict();
      $display("Comparisons %0d, mismatches %0d", nTests, failCount);
      if (failCount == 0 && nTests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : giveVerdict
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      nTests++;
      if (got !== exp) begin
         failCount++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One classic cycle; the answer is judged by the monitor, a hung slave ends the run
   task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d, input logic [32:0] e);
      int n;
      qExp.push_back(e);
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= d;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (!(wbAck || wbErr) && n < 20);
      if (n >= 20) begin
         failCount++;
         giveVerdict();
      end
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
      @(posedge clock);
   endtask : wb
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      wb(1'h1, a, d, 33'h0);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [32:0] e);
      wb(1'h0, a, 32'h0, e);
   endtask : rd
   // Oldest note is taken off whenever an answer or an event pulse shows
   always @(posedge clock) begin
      if (wbAck || wbErr) chk({wbErr, wbWe ? 32'h0 : wbDatR}, qExp.size() ? qExp.pop_front() : '1);
      if (pinEventLine !== 16'h0000) chk(pinEventLine, qEv.size() ? qEv.pop_front() : 16'h0000);
   end
   // Main sequence
   initial begin
      rst = 1'h1;
      {wbCyc, wbStb, wbWe, wbAdr, wbDatW, extLevel} = '0;
      wbSel = 4'hF;
      seed = 32'h0000A273;
      failCount = 0;
      nTests = 0;
      repeat (12) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
      rd(OFS_DIR, 33'h0FFFF);
      rd(OFS_GATE, 33'h0);
      rd(OFS_USET, 33'h0);
      rd(OFS_LEVEL, 33'h0);
      seed = xs(seed);
      extLevel <= seed[15:0];
      seed = xs(seed);
      lat = seed[15:0];
      wr(OFS_LATCH, seed);
      rd(OFS_LATCH, {17'h0, lat});
      seed = xs(seed);
      dir = seed[15:0];
      wr(OFS_DIR, seed);
      rd(OFS_DIR, {17'h0, dir});
      seed = xs(seed);
      lat = lat | seed[15:0];
      wr(OFS_DSET, seed);
      rd(OFS_DSET, {17'h0, lat});
      seed = xs(seed);
      lat = lat & ~seed[15:0];
      wr(OFS_DCLR, seed);
      rd(OFS_DCLR, {17'h0, lat});
      repeat (4) @(posedge clock);
      rd(OFS_LEVEL, {17'h0, (lat & ~dir) | (extLevel & dir)});
      rd(16'h0034, 33'h100000000);
      // Edge selects set up while the gate is still closed
      extLevel <= 16'h0000;
      wr(OFS_DIR, 32'h0000FFEF);
      wr(OFS_LATCH, 32'h0);
      wr(OFS_USET, 32'h0000003A);
      wr(OFS_UCLR, 32'h00000020);
      wr(OFS_WSET, 32'h0000000C);
      rd(OFS_UCLR, 33'h1A);
      rd(OFS_WCLR, 33'h0C);
      wr(OFS_GATE, 32'hFFFFFFFF);
      rd(OFS_GATE, 33'h1);
      qEv.push_back(16'h000A);
      extLevel <= 16'h000F;
      repeat (8) @(posedge clock);
      qEv.push_back(16'h000C);
      extLevel <= 16'h0000;
      repeat (8) @(posedge clock);
      qEv.push_back(16'h0010);
      wr(OFS_DSET, 32'h00000010);
      repeat (8) @(posedge clock);
      // A closed gate must swallow every edge
      wr(OFS_GATE, 32'h0);
      extLevel <= 16'h000F;
      repeat (8) @(posedge clock);
      chk(33'(qExp.size() + qEv.size()), 33'h0);
      giveVerdict();
   end
endmodule : gpio_port_with_edge_events_test
